// >>> testbench/test_wmg_top.sv
// Self-checking bench for the waveform marker generator.
`timescale 1ns/100ps
module test_wmg_top;
    import wmg_pkg::*;
    logic clk, rst_n, edit_req, edit_seg_volatile, toggle_req;
    logic play_valid, play_seq, edit_busy_r, edit_done_r, edit_err_r;
    wmg_op_type edit_op;
    logic [MRK_W-1:0] edit_marker, toggle_marker;
    logic [SEG_W-1:0] edit_seg, play_seg;
    logic [PT_W-1:0] edit_seg_points, edit_first, edit_last;
    logic [SKIP_W-1:0] edit_skip;
    logic [ENT_W-1:0] toggle_entry, view_entry, play_entry;
    logic [OFS_W-1:0] play_ofs;
    logic [MARKERS-1:0] view_en_r, event_out_r;
    logic [MARKERS-1:0] mem [0:SEG_COUNT-1][0:SEG_POINTS-1];
    logic [MARKERS-1:0] en [0:ENTRIES-1];
    logic [MARKERS-1:0] expq [$];
    logic [1:0] pv;
    int failures, check_count, exp_hits, hits, f;

    wmg_top dut (.clk(clk), .rst_n(rst_n), .edit_req(edit_req),
        .edit_op(edit_op), .edit_marker(edit_marker), .edit_seg(edit_seg),
        .edit_seg_volatile(edit_seg_volatile), .edit_skip(edit_skip),
        .edit_seg_points(edit_seg_points), .edit_first(edit_first),
        .edit_last(edit_last), .toggle_req(toggle_req),
        .toggle_entry(toggle_entry), .toggle_marker(toggle_marker),
        .view_entry(view_entry), .play_valid(play_valid),
        .play_seq(play_seq), .play_entry(play_entry), .play_seg(play_seg),
        .play_ofs(play_ofs), .edit_busy_r(edit_busy_r),
        .edit_done_r(edit_done_r), .edit_err_r(edit_err_r),
        .view_en_r(view_en_r), .event_out_r(event_out_r));
    wmg_event_scope scope (.clk(clk), .event_out_r(event_out_r), .hits(hits));

    // The sample clock runs at 10 MHz.
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            failures++;
            $display("BAD t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask

    task automatic end_sim;
        $display("checks=%0d failures=%0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Issue one edit, wait for its answer and update the shadow store.
    task automatic edit(input wmg_op_type op, input int mk, sg, vol, pts,
            input int fp, lp, sk);
        int n;
        bit bad;
        bad = !vol || fp == 0 || lp < fp || lp > pts;
        @(negedge clk);
        edit_op = op;
        {edit_marker, edit_seg} = {mk[1:0], sg[1:0]};
        {edit_seg_volatile, edit_seg_points} = {vol[0], pts[10:0]};
        {edit_first, edit_last, edit_skip} = {fp[10:0], lp[10:0], sk[9:0]};
        edit_req = 1'b1;
        @(negedge clk);
        edit_req = 1'b0;
        n = 0;
        while (edit_done_r !== 1'b1 && edit_err_r !== 1'b1 && n < 1100) begin
            @(negedge clk);
            n++;
        end
        chk(bad, edit_err_r);
        if (n == 1100) begin
            failures++;
            end_sim();
        end
        if (!bad && op == OP_SET_FIRST)
            mem[sg][0][mk] = 1'b1;
        else if (!bad && op == OP_CLR_ALL)
            for (int p = 0; p < pts; p++) mem[sg][p][mk] = 1'b0;
        else if (!bad)
            for (int p = fp; p <= lp; p += (op == OP_SET_RANGE) ? sk + 1 : 1)
                mem[sg][p - 1][mk] = (op == OP_SET_RANGE);
    endtask

    // Play a run of samples and note the expected outputs.
    task automatic play(input int sg, ent, sq, lo, hi);
        logic [3:0] e;
        for (int o = lo; o <= hi; o++) begin
            @(negedge clk);
            {play_valid, play_seq, play_entry} = {1'b1, sq[0], ent[2:0]};
            {play_seg, play_ofs} = {sg[1:0], o[9:0]};
            e = mem[sg][o] & (sq != 0 ? en[ent] : 4'hf);
            expq.push_back(e);
            exp_hits += $countones(e);
        end
        @(negedge clk);
        play_valid = 1'b0;
        repeat (3) @(negedge clk);
    endtask

    task automatic toggle(input int ent, mk);
        @(negedge clk);
        {toggle_req, toggle_entry, toggle_marker} = {1'b1, ent[2:0], mk[1:0]};
        view_entry = ent[2:0];
        en[ent][mk] = ~en[ent][mk];
        @(negedge clk);
        toggle_req = 1'b0;
        chk(en[ent], view_en_r);
    endtask

    // Follow taken samples and compare each output as it appears.
    always @(posedge clk) pv <= {pv[0], play_valid};
    always @(negedge clk) begin
        if (pv[1] === 1'b1) begin
            if (expq.size() == 0)
                chk(0, event_out_r);
            else
                chk(expq.pop_front(), event_out_r);
        end
    end

    // Main sequence.
    initial begin
        {rst_n, edit_req, toggle_req, play_valid, play_seq} = 5'h00;
        edit_op = OP_SET_RANGE;
        {edit_marker, edit_seg, edit_seg_volatile} = 5'h00;
        {edit_seg_points, edit_first, edit_last, edit_skip} = 43'h0;
        {toggle_entry, toggle_marker, view_entry} = 8'h00;
        {play_entry, play_seg, play_ofs} = 15'h0;
        foreach (en[i]) en[i] = 4'hf;
        void'($urandom(32'h60db));
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        chk(4'hf, view_en_r);
        for (int s = 0; s < SEG_COUNT; s++)
            for (int m = 0; m < MARKERS; m++)
                edit(OP_CLR_ALL, m, s, 1, 1024, 1, 1, 0);
        play(0, 0, 0, 0, 15);
        edit(OP_SET_RANGE, 0, 0, 1, 64, 10, 20, 0);
        edit(OP_SET_RANGE, 0, 0, 1, 64, 18, 26, 1);
        edit(OP_CLR_RANGE, 0, 0, 1, 64, 13, 17, 0);
        edit(OP_SET_FIRST, 1, 0, 1, 64, 1, 1, 0);
        edit(OP_SET_RANGE, 2, 0, 1, 64, 5, 5, 0);
        edit(OP_SET_RANGE, 3, 0, 1, 64, 5, 25, 1);
        edit(OP_SET_RANGE, 3, 0, 1, 64, 6, 30, 3);
        edit(OP_SET_RANGE, 2, 0, 1, 64, 64, 64, 0);
        edit(OP_SET_RANGE, 1, 0, 0, 64, 2, 3, 0);
        edit(OP_SET_FIRST, 2, 0, 0, 64, 1, 1, 0);
        edit(OP_SET_RANGE, 1, 0, 1, 64, 9, 8, 0);
        edit(OP_SET_RANGE, 1, 0, 1, 64, 60, 65, 0);
        edit(OP_SET_RANGE, 1, 0, 1, 64, 0, 3, 0);
        play(0, 0, 0, 0, 63);
        repeat (6) begin
            f = $urandom_range(64, 1);
            edit(OP_SET_RANGE, $urandom_range(3), 1, 1, 64, f,
                $urandom_range(64, f), $urandom_range(4));
        end
        play(1, 0, 0, 0, 63);
        for (int m = 1; m < MARKERS; m++) toggle(0, m);
        toggle(1, 0);
        toggle(1, 1);
        play(0, 0, 1, 0, 31);
        play(0, 1, 1, 0, 31);
        play(2, 1, 1, 0, 15);
        play(0, 1, 0, 0, 31);
        toggle(0, 1);
        play(1, 0, 1, 0, 63);
        chk(0, expq.size());
        chk(exp_hits, hits);
        end_sim();
    end
endmodule

// >>> testbench/wmg_event_scope.sv
// Instrument model that counts high samples on the event outputs.
`timescale 1ns/100ps
module wmg_event_scope (
    input wire logic clk, // Sample clock.
    input wire logic [wmg_pkg::MARKERS-1:0] event_out_r, // Observed lines.
    output int hits // High samples seen so far.
);
    import wmg_pkg::*;
    // Each marker line is watched on its own connector, once per sample.
    initial hits = 0;
    always @(posedge clk) begin
        hits <= hits + $countones(event_out_r);
    end
endmodule

// >>> testbench/wmg_props.sv
// Port checker for the waveform marker generator.
`timescale 1ns/100ps
module wmg_props (
    input wire logic clk, // Sample clock.
    input wire logic rst_n, // Reset, active low.
    input wire logic edit_req, // Edit request.
    input wire wmg_pkg::wmg_op_type edit_op, // Edit command.
    input wire logic edit_seg_volatile, // Volatile segment.
    input wire logic [wmg_pkg::PT_W-1:0] edit_seg_points, // Length.
    input wire logic [wmg_pkg::PT_W-1:0] edit_first, // First point.
    input wire logic [wmg_pkg::PT_W-1:0] edit_last, // Last point.
    input wire logic toggle_req, // Toggle request.
    input wire logic [wmg_pkg::MRK_W-1:0] toggle_marker, // Marker.
    input wire logic [wmg_pkg::ENT_W-1:0] toggle_entry, // Entry.
    input wire logic [wmg_pkg::ENT_W-1:0] view_entry, // Shown entry.
    input wire logic play_valid, // Sample plays.
    input wire logic edit_busy_r, // Busy.
    input wire logic edit_done_r, // Done pulse.
    input wire logic edit_err_r, // Refusal pulse.
    input wire logic [wmg_pkg::MARKERS-1:0] view_en_r, // Enables.
    input wire logic [wmg_pkg::MARKERS-1:0] event_out_r // Events.
);
    import wmg_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic take, rng, good;
    // Decode a request that an idle engine takes, and its legality.
    assign take = edit_req && !edit_busy_r;
    assign rng = edit_op == OP_SET_RANGE || edit_op == OP_CLR_RANGE;
    assign good = edit_seg_volatile && edit_first != 11'h000 &&
        edit_first <= edit_last && edit_last <= edit_seg_points &&
        edit_seg_points <= PT_MAX;
    a_err_pulse: assert property (
        edit_err_r |=> !edit_err_r) else $error("refusal pulse too long");
    a_done_pulse: assert property (
        edit_done_r |=> !edit_done_r) else $error("done pulse too long");
    a_refuse_store: assert property (
        take && !edit_seg_volatile |=> edit_err_r && !edit_busy_r)
        else $error("edit of stored segment taken");
    a_refuse_range: assert property (
        take && rng && edit_seg_volatile && edit_first != 11'h000 &&
        (edit_last < edit_first || edit_last > edit_seg_points)
        |=> edit_err_r) else $error("bad range not refused");
    a_accept_start: assert property (
        take && rng && good |=> edit_busy_r && !edit_err_r)
        else $error("legal edit not started");
    a_single_point: assert property (
        take && rng && good && edit_first == edit_last
        |=> edit_busy_r && !edit_done_r ##1 edit_busy_r && !edit_done_r
        ##1 edit_done_r && !edit_busy_r) else $error("single point walk");
    a_busy_cause: assert property (
        $rose(edit_busy_r) |-> $past(take)) else $error("busy without request");
    a_idle_output: assert property (
        !play_valid |=> ##1 event_out_r == EVT_IDLE)
        else $error("event output without sample");
    a_toggle_flip: assert property (
        toggle_req && toggle_entry == view_entry && $stable(view_entry) &&
        $past(rst_n) |=> view_en_r ==
        ($past(view_en_r) ^ (4'h1 << $past(toggle_marker))))
        else $error("toggle did not invert one enable");
    a_enables_hold: assert property (
        !toggle_req && $stable(view_entry) && $past(rst_n)
        |=> $stable(view_en_r)) else $error("enables changed");
endmodule

bind wmg_top wmg_props chk (.clk(clk), .rst_n(rst_n), .edit_req(edit_req),
    .edit_op(edit_op), .edit_seg_volatile(edit_seg_volatile),
    .edit_seg_points(edit_seg_points), .edit_first(edit_first),
    .edit_last(edit_last), .toggle_req(toggle_req),
    .toggle_marker(toggle_marker), .toggle_entry(toggle_entry),
    .view_entry(view_entry), .play_valid(play_valid),
    .edit_busy_r(edit_busy_r), .edit_done_r(edit_done_r),
    .edit_err_r(edit_err_r), .view_en_r(view_en_r),
    .event_out_r(event_out_r));

// >>> verilog/wmg_marker_mem.sv
// Marker bit store: one bit per marker per sample point.
`timescale 1ns/100ps
module wmg_marker_mem (
    input wire logic clk, // Sample clock.
    wmg_mem_if.store mem // Write and read port.
);
    import wmg_pkg::*;

    logic [MARKERS-1:0] bits [DEPTH];
    logic [MARKERS-1:0] rdata_r;

    // Bit writes touch only the chosen marker; reads are registered.
    always_ff @(posedge clk) begin
        if (mem.we) begin
            bits[mem.waddr][mem.wmark] <= mem.wdata; // RL3
        end
        rdata_r <= bits[mem.raddr]; // RL19
    end

    assign mem.rdata = rdata_r;
endmodule

// >>> verilog/wmg_mem_if.sv
// Connection between the marker editor and the marker bit store.
`timescale 1ns/100ps
interface wmg_mem_if;
    import wmg_pkg::*;

    logic we;
    logic [wmg_pkg::ADDR_W-1:0] waddr;
    logic [wmg_pkg::MRK_W-1:0] wmark;
    logic wdata;
    logic [wmg_pkg::ADDR_W-1:0] raddr;
    logic [wmg_pkg::MARKERS-1:0] rdata;

    // The control side writes single bits and reads whole words.
    modport ctrl (
        output we, waddr, wmark, wdata, raddr,
        input rdata
    );

    // The store side takes writes and answers reads a cycle later.
    modport store (
        input we, waddr, wmark, wdata, raddr,
        output rdata
    );
endinterface

// >>> verilog/wmg_pkg.sv
// Shared constants and types for the waveform marker generator.
package wmg_pkg;

    // ==========================================================
    // Geometry of the marker store
    // ==========================================================
    localparam int MARKERS = 4;
    localparam int MRK_W = 2;
    localparam int SEG_COUNT = 4;
    localparam int SEG_W = 2;
    localparam int SEG_POINTS = 1024;
    localparam int PT_W = 11;
    localparam int OFS_W = 10;
    localparam int ADDR_W = 12;
    localparam int DEPTH = 4096;
    localparam int SKIP_W = 10;

    // ==========================================================
    // Sequence table
    // ==========================================================
    localparam int ENTRIES = 8;
    localparam int ENT_W = 3;
    localparam logic [MARKERS-1:0] EN_RESET = 4'hf;

    // ==========================================================
    // Timing and constant values
    // ==========================================================
    localparam int LAG_SAMPLES = 2;
    localparam logic [PT_W-1:0] PT_FIRST = 11'h001;
    localparam logic [PT_W-1:0] PT_MAX = 11'h400;
    localparam logic [SKIP_W-1:0] SKIP_ZERO = 10'h000;
    localparam logic [MARKERS-1:0] EVT_IDLE = 4'h0;

    // ==========================================================
    // Edit commands and edit engine states
    // ==========================================================
    typedef enum logic [1:0] {
        OP_SET_RANGE = 2'h0,
        OP_CLR_RANGE = 2'h1,
        OP_SET_FIRST = 2'h2,
        OP_CLR_ALL = 2'h3
    } wmg_op_type;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_WALK = 2'h1,
        ST_DONE = 2'h3
    } wmg_state_type;

endpackage

// >>> verilog/wmg_top.sv
// Waveform marker generator: marker editing, sequence enables, playback.
// Overview of operation
// RL1 - Edits only allowed on volatile-store segments.
// RL2 - New set points add to existing ones.
// RL3 - Four markers; each edit picks one.
// RL4 - Range set marks first through last inclusive.
// RL5 - Operator keeps first <= last <= count.
// RL6 - First-point command marks only sample one.
// RL7 - Equal first and last marks one point.
// RL8 - Skip N marks start, then every N+1th.
// RL9 - Skip applies only while writing that range.
// RL10 - Enabled marker bit drives its event output.
// RL11 - Each sequence entry keeps per-marker enables.
// RL12 - Disabled markers hold their output inactive.
// RL13 - Enabling an empty marker changes no output.
// RL14 - Toggle inverts one marker enable of entry.
// RL15 - Enables persist across sequences until reset.
// RL16 - Cleared markers rest the output low.
// RL17 - Clear range clears first through last inclusive.
// RL18 - Output lags its sample by two samples.
// RL19 - Bits stored per sample, read with samples.
`timescale 1ns/100ps
module wmg_top (
    input wire logic clk, // Sample clock, 10 MHz.
    input wire logic rst_n, // Synchronous reset, active low.
    input wire logic edit_req, // One-cycle edit request.
    input wire wmg_pkg::wmg_op_type edit_op, // Edit command.
    input wire logic [wmg_pkg::MRK_W-1:0] edit_marker, // Marker 1..4 as 0..3.
    input wire logic [wmg_pkg::SEG_W-1:0] edit_seg, // Segment to edit.
    input wire logic edit_seg_volatile, // Segment is in volatile store.
    input wire logic [wmg_pkg::PT_W-1:0] edit_seg_points, // Segment length.
    input wire logic [wmg_pkg::PT_W-1:0] edit_first, // First point, 1-based.
    input wire logic [wmg_pkg::PT_W-1:0] edit_last, // Last point, 1-based.
    input wire logic [wmg_pkg::SKIP_W-1:0] edit_skip, // Skipped points.
    input wire logic toggle_req, // One-cycle enable toggle.
    input wire logic [wmg_pkg::ENT_W-1:0] toggle_entry, // Highlighted entry.
    input wire logic [wmg_pkg::MRK_W-1:0] toggle_marker, // Marker to toggle.
    input wire logic [wmg_pkg::ENT_W-1:0] view_entry, // Entry to show.
    input wire logic play_valid, // A sample plays this cycle.
    input wire logic play_seq, // Playing as part of a sequence.
    input wire logic [wmg_pkg::ENT_W-1:0] play_entry, // Current entry.
    input wire logic [wmg_pkg::SEG_W-1:0] play_seg, // Current segment.
    input wire logic [wmg_pkg::OFS_W-1:0] play_ofs, // Sample offset, 0-based.
    output logic edit_busy_r, // Edit in progress.
    output logic edit_done_r, // Edit finished, one cycle.
    output logic edit_err_r, // Edit refused, one cycle.
    output logic [wmg_pkg::MARKERS-1:0] view_en_r, // Enables of view_entry.
    output logic [wmg_pkg::MARKERS-1:0] event_out_r // Marker event outputs.
);
    import wmg_pkg::*;

    // ==========================================================
    // Helpers
    // ==========================================================

    // Store address of a 1-based point within a segment.
    // Each segment owns a fixed slot of the store; the point number
    // becomes an offset by dropping one, since points count from one.
    function automatic logic [ADDR_W-1:0] pt_addr(
        input logic [SEG_W-1:0] seg,
        input logic [PT_W-1:0] pt
    );
        logic [PT_W-1:0] ofs;
        ofs = pt - PT_FIRST;
        return {seg, ofs[OFS_W-1:0]};
    endfunction

    // The store sits behind an interface so that its write and read
    // ports travel together between the two modules.
    wmg_mem_if mem_bus ();

    wmg_marker_mem u_mem (
        .clk (clk),
        .mem (mem_bus)
    );

    // ==========================================================
    // Edit engine
    // ==========================================================
    // One accepted edit walks its range one point per clock. Requests
    // that arrive while a walk runs are dropped without a refusal, so
    // the controller must wait for the done pulse before the next one.
    // The store is not cleared by reset; every marker of every segment
    // must be cleared once before its points can be trusted.
    wmg_state_type state_r, state_nxt;
    logic [ADDR_W-1:0] addr_r, addr_nxt;
    logic [ADDR_W-1:0] last_r, last_nxt;
    logic [SKIP_W-1:0] skip_r, skip_nxt;
    logic [SKIP_W-1:0] skip_cnt_r, skip_cnt_nxt;
    logic [MRK_W-1:0] mark_r, mark_nxt;
    logic set_r, set_nxt;
    logic edit_busy_nxt;
    logic edit_done_nxt;
    logic edit_err_nxt;
    logic [PT_W-1:0] req_first;
    logic [PT_W-1:0] req_last;
    logic [SKIP_W-1:0] req_skip;
    logic req_ok;

    // Resolve each command into a point range and a skip count.
    always_comb begin
        req_first = edit_first;
        req_last = edit_last;
        req_skip = edit_skip;
        case (edit_op)
            OP_SET_FIRST: begin
                req_first = PT_FIRST; // RL6
                req_last = PT_FIRST; // RL6
                req_skip = SKIP_ZERO;
            end
            OP_CLR_ALL: begin
                req_first = PT_FIRST;
                req_last = edit_seg_points; // RL16
                req_skip = SKIP_ZERO;
            end
            OP_CLR_RANGE: begin
                req_skip = SKIP_ZERO; // RL17
            end
            default: begin
                req_skip = edit_skip; // RL8
            end
        endcase
        // The skip count is used only while this range is written.
        // A bad range or a segment outside volatile store is refused.
        req_ok = edit_seg_volatile // RL1
            && (req_first >= PT_FIRST)
            && (req_last >= req_first) // RL5
            && (req_last <= edit_seg_points) // RL5
            && (edit_seg_points <= PT_MAX);
    end

    // Next state of the edit engine: walk one point per clock.
    // The walk stops on the last point itself; the first is always written, the last only when the skip count lands on it.
    always_comb begin
        state_nxt = state_r;
        addr_nxt = addr_r;
        last_nxt = last_r;
        skip_nxt = skip_r;
        skip_cnt_nxt = skip_cnt_r;
        mark_nxt = mark_r;
        set_nxt = set_r;
        edit_done_nxt = 1'b0;
        edit_err_nxt = 1'b0;
        case (state_r)
            ST_IDLE: begin
                if (edit_req && req_ok) begin
                    state_nxt = ST_WALK;
                    addr_nxt = pt_addr(edit_seg, req_first); // RL4
                    last_nxt = pt_addr(edit_seg, req_last); // RL4
                    skip_nxt = req_skip;
                    skip_cnt_nxt = SKIP_ZERO; // RL8
                    mark_nxt = edit_marker; // RL3
                    set_nxt = (edit_op == OP_SET_RANGE)
                        || (edit_op == OP_SET_FIRST);
                end else if (edit_req) begin
                    edit_err_nxt = 1'b1; // RL1
                end
            end
            ST_WALK: begin
                // Count through the skipped points between marks.
                if (skip_cnt_r == skip_r) begin
                    skip_cnt_nxt = SKIP_ZERO; // RL8
                end else begin
                    skip_cnt_nxt = skip_cnt_r + 10'h001;
                end
                if (addr_r == last_r) begin
                    state_nxt = ST_DONE; // RL4
                end else begin
                    addr_nxt = addr_r + 12'h001;
                end
            end
            ST_DONE: begin
                // Busy has already fallen when done shows, so a new
                // request may be given in the same cycle as done.
                state_nxt = ST_IDLE;
                edit_done_nxt = 1'b1;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
        edit_busy_nxt = (state_nxt != ST_IDLE);
    end

    // Registers of the edit engine; the status outputs come straight
    // from these flip-flops.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            addr_r <= 12'h000;
            last_r <= 12'h000;
            skip_r <= 10'h000;
            skip_cnt_r <= 10'h000;
            mark_r <= 2'h0;
            set_r <= 1'b0;
            edit_busy_r <= 1'b0;
            edit_done_r <= 1'b0;
            edit_err_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            addr_r <= addr_nxt;
            last_r <= last_nxt;
            skip_r <= skip_nxt;
            skip_cnt_r <= skip_cnt_nxt;
            mark_r <= mark_nxt;
            set_r <= set_nxt;
            edit_busy_r <= edit_busy_nxt;
            edit_done_r <= edit_done_nxt;
            edit_err_r <= edit_err_nxt;
        end
    end

    // A write and a playback read of one address in the same cycle
    // return the old bits; the new value shows on the next pass.
    // Only the chosen marker bit is written, so other points and
    // markers keep their values; skipped points are left alone.
    assign mem_bus.we = (state_r == ST_WALK)
        && (skip_cnt_r == SKIP_ZERO); // RL9
    assign mem_bus.waddr = addr_r; // RL7
    assign mem_bus.wmark = mark_r; // RL3
    assign mem_bus.wdata = set_r; // RL2

    // ==========================================================
    // Sequence entry enables
    // ==========================================================
    logic [MARKERS-1:0] en_r [ENTRIES];
    logic [MARKERS-1:0] en_nxt [ENTRIES];
    logic [MARKERS-1:0] view_en_nxt;

    // Enables start all set, so a fresh sequence shows every marker
    // until the operator turns one off.
    // A toggle of an entry that is not shown still changes the table.
    // A toggle flips one marker of one entry; the table is only
    // rebuilt by reset, so it carries over to the next sequence.
    always_comb begin
        for (int i = 0; i < ENTRIES; i++) begin
            en_nxt[i] = en_r[i]; // RL15
        end
        if (toggle_req) begin
            en_nxt[toggle_entry][toggle_marker] =
                ~en_r[toggle_entry][toggle_marker]; // RL14
        end
        view_en_nxt = en_nxt[view_entry];
    end

    // Registers of the enable table.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int i = 0; i < ENTRIES; i++) begin
                en_r[i] <= EN_RESET;
            end
            view_en_r <= EVT_IDLE;
        end else begin
            for (int i = 0; i < ENTRIES; i++) begin
                en_r[i] <= en_nxt[i]; // RL11
            end
            view_en_r <= view_en_nxt;
        end
    end

    // ==========================================================
    // Playback pipeline
    // ==========================================================
    // Enables are taken with the sample, not with the output, so a
    // toggle during play acts from the next sample that enters.
    logic p1_valid_r, p1_valid_nxt;
    logic [MARKERS-1:0] p1_en_r, p1_en_nxt;
    logic [MARKERS-1:0] event_nxt;

    // The store read takes one cycle and the output flop a second,
    // so each marker leaves two samples behind its waveform sample.
    // The playback address is the segment slot plus the 0-based offset.
    assign mem_bus.raddr = {play_seg, play_ofs}; // RL19

    // Stage one picks the enables; stage two gates the stored bits.
    always_comb begin
        p1_valid_nxt = play_valid;
        if (play_seq) begin
            p1_en_nxt = en_r[play_entry]; // RL11
        end else begin
            p1_en_nxt = EN_RESET;
        end
        if (p1_valid_r) begin
            // An empty marker reads zero whatever its enable is.
            event_nxt = mem_bus.rdata & p1_en_r; // RL10 RL12 RL13
        end else begin
            event_nxt = EVT_IDLE; // RL16
        end
    end

    // Registers of the playback pipeline.
    // Event lines rest low whenever no sample is in the pipe.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            p1_valid_r <= 1'b0;
            p1_en_r <= EVT_IDLE;
            event_out_r <= EVT_IDLE;
        end else begin
            p1_valid_r <= p1_valid_nxt;
            p1_en_r <= p1_en_nxt;
            event_out_r <= event_nxt; // RL18
        end
    end

endmodule
